// *** hw/vcofwd_cfg.svh ***
`ifndef VCOFWD_CFG_SVH
`define VCOFWD_CFG_SVH
// Register offsets
`define VF_ADDR_INT 8'h03
`define VF_ADDR_FRAC 8'h04
`define VF_ADDR_FWD 8'h05
`define VF_ADDR_LOCK 8'h07
`define VF_ADDR_CAL 8'h0a
`define VF_ADDR_BAND 8'h10
// Field positions
`define VF_RELOCK_BIT 13
`define VF_CALDIS_BIT 11
`define VF_CLKSEL_HI 14
`define VF_CLKSEL_LO 13
`define VF_BANDRD_LO 16
`define VF_BAND_W 8
// Tuner side encodings
`define VF_TARGET_ID 3'h0
`define VF_CAL_REG 4'h0
`define VF_DIV_REG 4'h2
`define VF_DIV_BYPASS 6'h01
`define VF_DIV_FUND 6'h02
`define VF_PKT_BITS 5'h10
`define VF_BIT_LAST 4'hf
// Rates and tick exponents for select codes 0..3
`define VF_CLK_MHZ 50
`define VF_LINK_MAX_MHZ 50
`define VF_LINK_MIN_DIV ((`VF_CLK_MHZ + `VF_LINK_MAX_MHZ - 1) / `VF_LINK_MAX_MHZ)
`define VF_EXP_TABLE 12'hb10
`endif

// *** hw/vcofwd_pkg.sv ***
package vcofwd_pkg;
    typedef struct packed
    {
        logic [8:0] payload;
        logic [3:0] index;
        logic [2:0] target;
    } vcofwd_pkt_t;

    typedef enum logic [2:0]
    {
        CAL_IDLE = 3'b000,
        CAL_ENTER = 3'b001,
        CAL_PUSH = 3'b011,
        CAL_SETTLE = 3'b111,
        CAL_LEAVE = 3'b110
    } vcofwd_cal_t;
endpackage : vcofwd_pkg

// *** hw/vcofwd_forwarder.sv ***
// Contract
// R1: Synthesizer register writes take effect in the cycle they are made.
// R2: Each forwarding register write is shifted out as 16 bits, MSB first.
// R3: Link runs at calibration clock rate from select field, never above 50 MHz.
// R4: Tuner sub-registers are write-only; nothing reads them back to the host. Code returns sub-register 0 bits 8:1 as band readback.
// R5: Active tuning band is readable through the calibration config register.
// R6: Tuner side decodes bits 2:0 as target (must be zero), 6:3 as index.
// R7: Tuner side stores bits 15:7 as payload into the indexed sub-register.
// R8: Calibration writes go to the target and index held in forwarding register.
// R9: Calibration runs only when forwarding register low seven bits are zero.
// R10: Host clears forwarding low seven bits after tuner writes, before retune.
// R11: Integer or fractional divider write starts a frequency change.
// R12: Forwarding register is written whole; host supplies a correct payload.
// R13: Present band switch settings are readable in low byte of band register.
// R14: To keep a band, host copies band readback into the forwarding payload. Host model forces band bit 5 to one in the copy.
// R15: Host without readback writes zero then a divider write to recalibrate.
// R16: Sub-register 0 calibration bit picks reference voltage or loop for tuning.
// R17: With auto relock on, lock loss reruns calibration exactly once.
// R18: Divider setting one bypasses to doubled output; two gives fundamental.
// R19: Band selects one of two cores, each with 128 sub-bands.
// R20: Calibration clock is reference period times 2^m, m from 0, 2, 4, 5.
// R21: Calibration enabled when disable bit is zero, manual band when one.
// R22: Calibration sets cal bit, binary-searches band, then clears cal bit.
// R23: No further transfer starts until the current packet's last bit is sent.
`timescale 1ns/1ps
`include "vcofwd_cfg.svh"

module vcofwd_forwarder
    import vcofwd_pkg::*;
#(
    parameter int DW = 24
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic regWe,
    input wire logic regRe,
    input wire logic [7:0] regAddr,
    input wire logic [DW-1:0] regWdata,
    output logic [DW-1:0] regRdata_r,
    output logic regRdValid_r,
    output logic fwdReady_r,
    input wire logic vcoHigh,
    input wire logic lockLost,
    output logic linkClk_r,
    output logic linkData_r,
    output logic linkFrame_r,
    output logic tuneFromRef_r,
    output logic divBypass_r,
    output logic divFundamental_r,
    output logic calBusy_r,
    output logic calFailed_r
);
    vcofwd_pkt_t fwdReg_r;
    logic [DW-1:0] intDiv_r;
    logic [DW-1:0] fracDiv_r;
    logic [DW-1:0] lockCfg_r;
    logic [DW-1:0] calCfg_r;
    logic [8:0] subReg_r [16];
    vcofwd_pkt_t buf_r [2];
    logic wrPtr_r;
    logic rdPtr_r;
    logic [1:0] count_r;
    logic [1:0] count_nxt;
    logic [15:0] shift_r;
    logic [3:0] bitCnt_r;
    logic shBusy_r;
    logic [5:0] divCnt_r;
    logic [5:0] divLimit;
    logic [2:0] expSel;
    logic tick;
    logic [15:0] rxShift_r;
    logic [3:0] rxCnt_r;
    logic rxDone;
    vcofwd_pkt_t rxWord;
    vcofwd_cal_t state_r;
    logic [2:0] bit_r;
    logic [`VF_BAND_W-1:0] band_r;
    logic [`VF_BAND_W-1:0] bitMask;
    logic lockLostD_r;
    logic relockUsed_r;
    logic freqChange;
    logic hostPush;
    logic calPush;
    logic linkIdle;
    logic pop;
    logic calStart;
    logic relockReq;
    logic fwdLowZero;
    vcofwd_pkt_t calPkt;

    // Register access decode
    assign freqChange = ce && regWe && (regAddr == `VF_ADDR_INT || regAddr == `VF_ADDR_FRAC); // [R11]
    assign hostPush = ce && regWe && regAddr == `VF_ADDR_FWD && fwdReady_r; // [R2]
    assign fwdLowZero = {fwdReg_r.index, fwdReg_r.target} == 7'h00;

    // Calibration clock tick, 2^m reference periods
    assign expSel = 3'(`VF_EXP_TABLE >> (3 * calCfg_r[`VF_CLKSEL_HI:`VF_CLKSEL_LO]));
    assign divLimit = 6'((7'h01 << expSel) - 7'h01); // [R20]
    assign tick = ce && divCnt_r == divLimit; // [R3]

    // Link shares one transfer at a time
    assign linkIdle = !shBusy_r && count_r == 2'h0; // [R23]
    assign pop = tick && !shBusy_r && count_r != 2'h0;

    // Calibration packet targets the stored fields
    assign bitMask = `VF_BAND_W'(9'h001 << bit_r);
    always_comb
    begin
        calPkt.target = fwdReg_r.target; // [R8]
        calPkt.index = fwdReg_r.index; // [R8]
        case (state_r)
            CAL_ENTER: calPkt.payload = {band_r, 1'b1}; // [R22]
            CAL_PUSH: calPkt.payload = {band_r | bitMask, 1'b1};
            default: calPkt.payload = {band_r, 1'b0};
        endcase
    end
    assign calPush = ce && !hostPush && linkIdle
        && (state_r == CAL_ENTER || state_r == CAL_PUSH || state_r == CAL_LEAVE); // [R23]

    assign relockReq = ce && lockLost && !lockLostD_r && lockCfg_r[`VF_RELOCK_BIT]
        && !relockUsed_r; // [R17]
    assign calStart = !calCfg_r[`VF_CALDIS_BIT] && (freqChange || relockReq); // [R21]

    always_comb
    begin
        count_nxt = count_r;
        if ((hostPush || calPush) && !pop)
        begin
            count_nxt = count_r + 2'h1;
        end
        else if (pop && !(hostPush || calPush))
        begin
            count_nxt = count_r - 2'h1;
        end
    end

    // Synthesizer registers, written directly
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fwdReg_r <= '0;
            intDiv_r <= '0;
            fracDiv_r <= '0;
            lockCfg_r <= '0;
            calCfg_r <= '0;
        end
        else if (ce && regWe)
        begin
            case (regAddr)
                `VF_ADDR_INT: intDiv_r <= regWdata; // [R1]
                `VF_ADDR_FRAC: fracDiv_r <= regWdata; // [R1]
                `VF_ADDR_FWD:
                begin
                    if (fwdReady_r)
                    begin
                        fwdReg_r <= vcofwd_pkt_t'(regWdata[15:0]); // [R12]
                    end
                end
                `VF_ADDR_LOCK: lockCfg_r <= regWdata;
                `VF_ADDR_CAL: calCfg_r <= regWdata;
                default: ;
            endcase
        end
    end

    // Register reads; tuner sub-registers read back only as sub-register 0 bits 8:1
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            regRdata_r <= '0;
            regRdValid_r <= 1'b0;
        end
        else if (ce)
        begin
            regRdValid_r <= regRe; // [R4]
            regRdata_r <= '0;
            if (regRe)
            begin
                case (regAddr)
                    `VF_ADDR_INT: regRdata_r <= intDiv_r;
                    `VF_ADDR_FRAC: regRdata_r <= fracDiv_r;
                    `VF_ADDR_FWD: regRdata_r <= DW'(fwdReg_r);
                    `VF_ADDR_LOCK: regRdata_r <= lockCfg_r;
                    `VF_ADDR_CAL:
                    begin
                        regRdata_r <= calCfg_r;
                        regRdata_r[`VF_BANDRD_LO +: `VF_BAND_W] <= subReg_r[`VF_CAL_REG][8:1]; // [R5]
                    end
                    `VF_ADDR_BAND: regRdata_r <= DW'(subReg_r[`VF_CAL_REG][8:1]); // [R13]
                    default: regRdata_r <= '0;
                endcase
            end
        end
    end

    // Two-entry packet buffer
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
            fwdReady_r <= 1'b0;
            buf_r[0] <= '0;
            buf_r[1] <= '0;
        end
        else if (ce)
        begin
            if (hostPush || calPush)
            begin
                buf_r[wrPtr_r] <= hostPush ? vcofwd_pkt_t'(regWdata[15:0]) : calPkt; // [R2]
                wrPtr_r <= !wrPtr_r;
            end
            if (pop)
            begin
                rdPtr_r <= !rdPtr_r;
            end
            count_r <= count_nxt;
            fwdReady_r <= count_nxt != 2'h2;
        end
    end

    // Calibration clock divider
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            divCnt_r <= 6'h00;
        end
        else if (ce)
        begin
            divCnt_r <= (divCnt_r >= divLimit) ? 6'h00 : divCnt_r + 6'h01; // [R20]
        end
    end

    // Serializer, one bit per calibration tick
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_r <= 16'h0000;
            bitCnt_r <= 4'h0;
            shBusy_r <= 1'b0;
            linkClk_r <= 1'b0;
            linkData_r <= 1'b0;
            linkFrame_r <= 1'b0;
        end
        else if (ce)
        begin
            linkClk_r <= tick && shBusy_r;
            if (tick)
            begin
                linkFrame_r <= shBusy_r;
                if (shBusy_r)
                begin
                    linkData_r <= shift_r[15]; // [R2]
                    shift_r <= {shift_r[14:0], 1'b0};
                    bitCnt_r <= bitCnt_r - 4'h1;
                    shBusy_r <= bitCnt_r != 4'h0; // [R23]
                end
                else if (pop)
                begin
                    shift_r <= buf_r[rdPtr_r];
                    bitCnt_r <= `VF_BIT_LAST;
                    shBusy_r <= 1'b1;
                end
            end
        end
    end

    // Tuner side receiver and decode
    assign rxDone = ce && linkClk_r && rxCnt_r == `VF_BIT_LAST;
    assign rxWord = vcofwd_pkt_t'({rxShift_r[14:0], linkData_r});
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rxShift_r <= 16'h0000;
            rxCnt_r <= 4'h0;
            for (int i = 0; i < 16; i++)
            begin
                subReg_r[i] <= 9'h000;
            end
        end
        else if (ce && linkClk_r)
        begin
            rxShift_r <= {rxShift_r[14:0], linkData_r};
            rxCnt_r <= rxCnt_r + 4'h1;
            if (rxDone && rxWord.target == `VF_TARGET_ID) // [R6]
            begin
                subReg_r[rxWord.index] <= rxWord.payload; // [R7]
            end
        end
    end

    // Tuning source and output divider mode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tuneFromRef_r <= 1'b0;
            divBypass_r <= 1'b0;
            divFundamental_r <= 1'b0;
        end
        else if (ce)
        begin
            tuneFromRef_r <= subReg_r[`VF_CAL_REG][0]; // [R16]
            divBypass_r <= subReg_r[`VF_DIV_REG][5:0] == `VF_DIV_BYPASS; // [R18]
            divFundamental_r <= subReg_r[`VF_DIV_REG][5:0] == `VF_DIV_FUND; // [R18]
        end
    end

    // Relock bookkeeping
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lockLostD_r <= 1'b0;
            relockUsed_r <= 1'b0;
        end
        else if (ce)
        begin
            lockLostD_r <= lockLost;
            if (freqChange)
            begin
                relockUsed_r <= 1'b0;
            end
            else if (relockReq)
            begin
                relockUsed_r <= 1'b1; // [R17]
            end
        end
    end

    // Calibration sequencer: core bit plus 7-bit sub-band
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= CAL_IDLE;
            bit_r <= 3'h0;
            band_r <= '0;
            calBusy_r <= 1'b0;
            calFailed_r <= 1'b0;
        end
        else if (ce)
        begin
            calBusy_r <= state_r != CAL_IDLE;
            case (state_r)
                CAL_IDLE:
                begin
                    if (calStart && !fwdLowZero)
                    begin
                        calFailed_r <= 1'b1; // [R9]
                    end
                    else if (calStart)
                    begin
                        calFailed_r <= 1'b0;
                        band_r <= '0; // [R19]
                        bit_r <= 3'h7;
                        state_r <= CAL_ENTER; // [R11]
                    end
                end
                CAL_ENTER:
                begin
                    if (calPush)
                    begin
                        state_r <= CAL_PUSH;
                    end
                end
                CAL_PUSH:
                begin
                    if (calPush)
                    begin
                        band_r <= band_r | bitMask;
                        state_r <= CAL_SETTLE;
                    end
                end
                CAL_SETTLE:
                begin
                    if (linkIdle && tick)
                    begin
                        if (!vcoHigh)
                        begin
                            band_r <= band_r & ~bitMask; // [R22]
                        end
                        if (bit_r == 3'h0)
                        begin
                            state_r <= CAL_LEAVE;
                        end
                        else
                        begin
                            bit_r <= bit_r - 3'h1;
                            state_r <= CAL_PUSH;
                        end
                    end
                end
                CAL_LEAVE:
                begin
                    if (calPush)
                    begin
                        state_r <= CAL_IDLE; // [R22]
                    end
                end
                default: state_r <= CAL_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst || !ce);

    a_direct_write: assert property (regWe && regAddr == `VF_ADDR_INT |=> intDiv_r == $past(regWdata)) else $error("divider write not immediate"); // [R1]
    a_tuner_store: assert property (rxDone && rxWord.target == `VF_TARGET_ID |=> subReg_r[$past(rxWord.index)] == $past(rxWord.payload)) else $error("packet not stored"); // [R6] [R7]
    a_link_rate: assert property (tick && calCfg_r[`VF_CLKSEL_HI:`VF_CLKSEL_LO] != 2'h0 |=> !tick [*3]) else $error("link tick too fast"); // [R3] [R20]
    a_cal_gated: assert property (state_r == CAL_IDLE && calStart && !fwdLowZero |=> state_r == CAL_IDLE && calFailed_r) else $error("calibration ran with nonzero fields"); // [R9]
    a_cal_starts: assert property (state_r == CAL_IDLE && freqChange && !calCfg_r[`VF_CALDIS_BIT] && fwdLowZero |=> state_r == CAL_ENTER) else $error("frequency change did not calibrate"); // [R11] [R21]
    a_cal_disabled: assert property (state_r == CAL_IDLE && calCfg_r[`VF_CALDIS_BIT] |=> state_r == CAL_IDLE) else $error("calibration while disabled"); // [R21]
    a_hold_off: assert property (calPush |-> !shBusy_r && count_r == 2'h0) else $error("transfer during packet"); // [R23]
    a_cal_target: assert property (calPush |-> calPkt.index == fwdReg_r.index && calPkt.target == fwdReg_r.target) else $error("calibration target wrong"); // [R8]
    a_band_read: assert property (regRe && regAddr == `VF_ADDR_BAND |=> regRdata_r[7:0] == $past(subReg_r[`VF_CAL_REG][8:1])) else $error("band readback wrong"); // [R13]
    a_tune_source: assert property (rxDone && rxWord.target == `VF_TARGET_ID && rxWord.index == `VF_CAL_REG |=> ##1 tuneFromRef_r == $past(rxWord.payload[0], 2)) else $error("tuning source wrong"); // [R16]
    a_relock_once: assert property (relockReq && state_r == CAL_IDLE && !calCfg_r[`VF_CALDIS_BIT] && !freqChange |=> relockUsed_r) else $error("relock not recorded"); // [R17]
    a_div_modes: assert property (divBypass_r |-> !divFundamental_r) else $error("divider modes overlap"); // [R18]

    c_host_forward: cover property (hostPush ##[1:40] rxDone);
    c_cal_done: cover property (state_r == CAL_LEAVE ##1 state_r == CAL_IDLE);
    c_buffer_full: cover property (count_r == 2'h2);
    c_relock: cover property (relockReq);
endmodule : vcofwd_forwarder

// *** tb/vcofwd_host_model.sv ***
`timescale 1ns/1ps
`include "vcofwd_cfg.svh"
module vcofwd_host_model
(
    input wire logic clk,
    input wire logic fwdReady_r,
    input wire logic regRdValid_r,
    input wire logic [23:0] regRdata_r,
    output logic regWe,
    output logic regRe,
    output logic [7:0] regAddr,
    output logic [23:0] regWdata
);
    logic [23:0] rdVal;
    initial
    begin
        regWe = 1'b0;
        regRe = 1'b0;
        regAddr = 8'h00;
        regWdata = 24'h000000;
    end
    // Write; forwarding writes wait for room unless pushed anyway
    task automatic wr(input logic [7:0] a, input logic [23:0] d, input bit pushAnyway);
        int n;
        n = 0;
        @(negedge clk);
        while (a == `VF_ADDR_FWD && !pushAnyway && fwdReady_r !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        regAddr = a;
        regWdata = d;
        regWe = 1'b1;
        @(negedge clk);
        regWe = 1'b0;
        regAddr = ~a;
        regWdata = ~d;
    endtask : wr
    // Read; answer taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        regAddr = a;
        regRe = 1'b1;
        @(negedge clk);
        regRe = 1'b0;
        regAddr = ~a;
        rdVal = (regRdValid_r === 1'b1) ? regRdata_r : 24'hxxxxxx;
    endtask : rd
    // Keep band: copy readback into payload with band bit 5 forced to one, clear target and index
    task automatic keep_band();
        rd(`VF_ADDR_BAND);
        wr(`VF_ADDR_FWD, {8'h00, rdVal[7:6], 1'b1, rdVal[4:0], 8'h00}, 1'b0);
    endtask : keep_band
    // Without readback: clear whole register, then a divider write
    task automatic blind_relock(input logic [7:0] divAddr, input logic [23:0] d);
        wr(`VF_ADDR_FWD, 24'h000000, 1'b0);
        wr(divAddr, d, 1'b0);
    endtask : blind_relock
endmodule : vcofwd_host_model

// *** tb/vcofwd_forwarder_test.sv ***
`timescale 1ns/1ps
`include "vcofwd_cfg.svh"
module vcofwd_forwarder_test
    import vcofwd_pkg::*;
;
    logic clk, sys_rst, ce, vcoHigh, lockLost, regWe, regRe;
    logic [7:0] regAddr, tgt;
    logic [23:0] regWdata, regRdata_r, v;
    logic regRdValid_r, fwdReady_r, linkClk_r, linkData_r, linkFrame_r, tuneFromRef_r;
    logic divBypass_r, divFundamental_r, calBusy_r, calFailed_r, sawRef;
    logic [15:0] shiftReg, lastPkt, pkts[$];
    logic [15:0] tabPkt[4] = '{16'h0090, 16'h0111, 16'h0110, 16'h0310};
    logic [1:0] tabDiv[4] = '{2'b10, 2'b10, 2'b01, 2'b00};
    int n_errors, check_count, nBits, cyc, lastStrobe, lastGap;
    vcofwd_forwarder #(.DW(24)) vcofwd_forwarder_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .regWe(regWe), .regRe(regRe), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata_r(regRdata_r), .regRdValid_r(regRdValid_r), .fwdReady_r(fwdReady_r),
        .vcoHigh(vcoHigh), .lockLost(lockLost), .linkClk_r(linkClk_r), .linkData_r(linkData_r),
        .linkFrame_r(linkFrame_r), .tuneFromRef_r(tuneFromRef_r), .divBypass_r(divBypass_r),
        .divFundamental_r(divFundamental_r), .calBusy_r(calBusy_r), .calFailed_r(calFailed_r));
    vcofwd_host_model vcofwd_host_model_i (.clk(clk), .fwdReady_r(fwdReady_r),
        .regRdValid_r(regRdValid_r), .regRdata_r(regRdata_r), .regWe(regWe), .regRe(regRe),
        .regAddr(regAddr), .regWdata(regWdata));
    always #10 clk = ~clk;
    // Link receiver: collects packets MSB first, measures tick spacing
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (sys_rst)
            nBits = 0;
        else if (linkClk_r === 1'b1)
        begin
            shiftReg = {shiftReg[14:0], linkData_r};
            chk(24'(linkFrame_r), 24'h1, "frame with bit");
            if (nBits == 15)
            begin
                pkts.push_back(shiftReg);
                lastPkt = shiftReg;
                lastGap = cyc - lastStrobe;
                nBits = 0;
            end
            else
                nBits++;
            lastStrobe = cyc;
        end
        if (calBusy_r === 1'b1 && tuneFromRef_r === 1'b1)
            sawRef = 1'b1;
    end
    // Band search answer: keep a trial bit while the trial stays at or below target
    always @(negedge clk)
        vcoHigh = (lastPkt[15:8] <= tgt);
    function automatic int tick_len(input int code);
        return 1 << (code == 0 ? 0 : code == 1 ? 2 : code == 2 ? 4 : 5);
    endfunction : tick_len
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_cyc
    task automatic wait_pkts(input int n);
        int k;
        k = 0;
        while (pkts.size() < n && k < 6000)
        begin
            @(negedge clk);
            k++;
        end
    endtask : wait_pkts
    // Follows one calibration run whose packets start at position base
    task automatic cal_run(input int base);
        int n;
        n = 0;
        sawRef = 1'b0;
        tgt = 8'($urandom);
        while (calBusy_r !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        while (calBusy_r === 1'b1 && n < 4000)
        begin
            @(negedge clk);
            n++;
        end
        wait_pkts(base + 10);
        wait_cyc(3);
        chk(24'(pkts.size()), 24'(base + 10), "cal packet count");
        for (int i = base; i < pkts.size(); i++)
            chk(24'(pkts[i][6:0]), 24'h0, "cal address");
        chk(24'(pkts[base][7]), 24'h1, "cal bit set first");
        chk(24'(pkts[base + 9]), {8'h00, tgt, 8'h00}, "final band");
        chk(24'({sawRef, tuneFromRef_r, calFailed_r}), 24'h4, "tuning source");
        vcofwd_host_model_i.rd(`VF_ADDR_BAND);
        chk(vcofwd_host_model_i.rdVal, {16'h0, tgt}, "band readback");
        vcofwd_host_model_i.rd(`VF_ADDR_CAL);
        chk(24'(vcofwd_host_model_i.rdVal[23:16]), 24'(tgt), "band in cal reg");
    endtask : cal_run
    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'h44ebf495));
        {clk, ce, sys_rst, vcoHigh, lockLost, tgt, lastPkt} = {3'b011, 2'b00, 8'h00, 16'h0};
        {n_errors, check_count, nBits, cyc, lastStrobe, lastGap} = '0;
        wait_cyc(3);
        sys_rst = 1'b0;
        @(negedge clk);
        chk(24'(fwdReady_r), 24'h1, "ready after reset");
        vcofwd_host_model_i.rd(8'h21);
        chk(vcofwd_host_model_i.rdVal, 24'h0, "unmapped read");
        vcofwd_host_model_i.wr(`VF_ADDR_CAL, 24'h000000, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            pkts.delete();
            vcofwd_host_model_i.wr(`VF_ADDR_FWD, {8'h00, tabPkt[i]}, 1'b0);
            wait_pkts(1);
            wait_cyc(3);
            chk(24'(pkts[0]), 24'(tabPkt[i]), "table packet");
            chk(24'({divBypass_r, divFundamental_r}), 24'(tabDiv[i]), "divider");
        end
        for (int code = 0; code < 4; code++)
        begin
            vcofwd_host_model_i.wr(`VF_ADDR_CAL, {9'h0, 2'(code), 13'h0}, 1'b0);
            vcofwd_host_model_i.rd(`VF_ADDR_CAL);
            chk(24'(vcofwd_host_model_i.rdVal[15:0]), {9'h0, 2'(code), 13'h0}, "cal reg");
            pkts.delete();
            v = {8'h00, 16'($urandom)};
            vcofwd_host_model_i.wr(`VF_ADDR_FWD, v, 1'b0);
            wait_pkts(1);
            chk(24'(pkts[0]), v, "random packet");
            chk(24'(lastGap), 24'(tick_len(code)), "tick spacing");
        end
        pkts.delete();
        for (int i = 0; i < 3; i++)
            vcofwd_host_model_i.wr(`VF_ADDR_FWD, {8'h00, tabPkt[i] ^ 16'(i * 16'h1357)}, 1'b0);
        chk(24'(fwdReady_r), 24'h0, "buffer full");
        vcofwd_host_model_i.wr(`VF_ADDR_FWD, 24'h00dead, 1'b1);
        wait_pkts(3);
        wait_cyc(700);
        chk(24'(pkts.size()), 24'h3, "refused write dropped");
        for (int i = 0; i < 3; i++)
            chk(24'(pkts[i]), {8'h00, tabPkt[i] ^ 16'(i * 16'h1357)}, "order");
        vcofwd_host_model_i.wr(`VF_ADDR_CAL, 24'h002000, 1'b0);
        vcofwd_host_model_i.wr(`VF_ADDR_FWD, 24'h000018, 1'b0);
        wait_cyc(200);
        pkts.delete();
        vcofwd_host_model_i.wr(`VF_ADDR_INT, 24'h000040, 1'b0);
        wait_cyc(60);
        chk(24'({calFailed_r, calBusy_r, 1'b0} | 3'(pkts.size())), 24'h4, "refused cal");
        vcofwd_host_model_i.keep_band();
        wait_cyc(200);
        pkts.delete();
        vcofwd_host_model_i.wr(`VF_ADDR_INT, 24'h000041, 1'b0);
        cal_run(0);
        pkts.delete();
        vcofwd_host_model_i.blind_relock(`VF_ADDR_FRAC, {8'h00, 16'($urandom)});
        cal_run(1);
        chk(24'(pkts[0]), 24'h0, "cleared packet first");
        vcofwd_host_model_i.wr(`VF_ADDR_LOCK, 24'h002000, 1'b0);
        pkts.delete();
        lockLost = 1'b1;
        cal_run(0);
        lockLost = 1'b0;
        wait_cyc(5);
        lockLost = 1'b1;
        wait_cyc(60);
        chk(24'({calBusy_r, 1'b0} | 2'(pkts.size() - 10)), 24'h0, "relock only once");
        lockLost = 1'b0;
        vcofwd_host_model_i.wr(`VF_ADDR_CAL, 24'h002800, 1'b0);
        pkts.delete();
        vcofwd_host_model_i.wr(`VF_ADDR_INT, 24'h000042, 1'b0);
        wait_cyc(60);
        chk(24'({calBusy_r, 1'b0} | 2'(pkts.size())), 24'h0, "manual band mode");
        report_and_stop();
    end
endmodule : vcofwd_forwarder_test
